// [rtl/epis_pkg.sv]
// Constants, types and register map of the external pin interrupt sense block.
package epis_pkg;
    // ==========================================================
    // Timing.
    localparam int CLK_NS = 100;
    localparam int WDT_NS = 1000;
    localparam int WDT_CYC = (WDT_NS / CLK_NS < 1) ? 1 : WDT_NS / CLK_NS;
    localparam int WDT_W = $clog2(WDT_CYC + 1);
    localparam int STARTUP_NS = 4000;
    localparam int STARTUP_CYC = (STARTUP_NS / CLK_NS < 1) ? 1 : STARTUP_NS / CLK_NS;
    localparam int STARTUP_W = $clog2(STARTUP_CYC + 1);
    // ==========================================================
    // Register offsets.
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CSR = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_FLAG = 8'h0C;
    localparam logic [7:0] OFF_GIE = 8'h10;
    localparam logic [7:0] OFF_STS = 8'h14;
    localparam logic [7:0] OFF_IMSK = 8'h18;
    localparam logic [7:0] OFF_PIN = 8'h1C;
    // ==========================================================
    // Field positions.
    localparam int B_SENSE_A = 0;
    localparam int B_SENSE_B = 2;
    localparam int B_SLEEP_SEL0 = 4;
    localparam int B_SLEEP_SEL1 = 5;
    localparam int B_SLEEP_ALLOW = 6;
    localparam int B_SLEEP_SEL2 = 7;
    localparam int B_SENSE_C = 6;
    localparam int B_PIN_C = 5;
    localparam int B_PIN_A = 6;
    localparam int B_PIN_B = 7;
    localparam int B_GIE = 0;
    localparam int STS_W = 4;
    localparam int STS_WAKE = 3;
    // ==========================================================
    // Reset values and the idle sleep select code.
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic RST_SENSE_C = 1'h0;
    localparam logic [2:0] RST_PINS = 3'h0;
    localparam logic RST_GIE = 1'h0;
    localparam logic [3:0] RST_STS = 4'h0;
    localparam logic [2:0] SLEEP_IDLE = 3'h0;
    // ==========================================================
    // Types.
    typedef enum logic [1:0] {
        SENSE_LOW = 2'h0, SENSE_ANY = 2'h1, SENSE_FALL = 2'h2, SENSE_RISE = 2'h3
    } epis_sense_t;
    typedef enum logic [2:0] {S_RUN = 3'h1, S_IDLE = 3'h2, S_DEEP = 3'h4} epis_sleep_t;
    typedef enum logic [2:0] {W_WAIT = 3'h1, W_SAMP = 3'h2, W_START = 3'h4} epis_wake_t;
endpackage

// [rtl/epis_wake_if.sv]
// Signals between the sense block and its level wake-up sampler.
`timescale 1ns/1ns
interface epis_wake_if;
    logic deepSleep;
    logic wdtTick;
    logic lvlLow;
    logic wakeReq;
    modport ctl (output deepSleep, output wdtTick, output lvlLow, input wakeReq);
    modport wake (input deepSleep, input wdtTick, input lvlLow, output wakeReq);
endinterface

// [rtl/epis_sync.sv]
// Two-flop synchroniser for the three interrupt pins.
`timescale 1ns/1ns
module epis_sync (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [2:0] d,
    output logic [2:0] q
);
    logic [2:0] meta;
    logic [2:0] next_meta;
    logic [2:0] next_q;

    always_comb begin
        next_meta = d;
        next_q = meta;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta <= 3'h7;
            q <= 3'h7;
        end else begin
            meta <= next_meta;
            q <= next_q;
        end
    end
endmodule

// [rtl/epis_wake.sv]
// Level wake-up sampler clocked by watchdog oscillator ticks.
`timescale 1ns/1ns
module epis_wake (
    input wire logic core_clk,
    input wire logic rst,
    epis_wake_if.wake wk
);
    import epis_pkg::*;

    epis_wake_t state;
    epis_wake_t next_state;
    logic [STARTUP_W-1:0] cnt;
    logic [STARTUP_W-1:0] next_cnt;
    logic wakeReq;
    logic next_wakeReq;

    // ==========================================================
    // Two low samples start the start-up count; its end wakes.
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_wakeReq = 1'b0;
        case (state)
            W_WAIT: begin
                if (wk.deepSleep && wk.wdtTick && wk.lvlLow) begin
                    next_state = W_SAMP;
                end
            end
            W_SAMP: begin
                if (!wk.deepSleep) begin
                    next_state = W_WAIT;
                end else if (wk.wdtTick) begin
                    next_state = wk.lvlLow ? W_START : W_WAIT;
                    next_cnt = '0;
                end
            end
            W_START: begin
                if (cnt == STARTUP_W'(STARTUP_CYC - 1)) begin
                    next_state = W_WAIT;
                    next_wakeReq = wk.deepSleep;
                end else begin
                    next_cnt = cnt + STARTUP_W'(1);
                end
            end
            default: begin
                next_state = W_WAIT;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= W_WAIT;
            cnt <= '0;
            wakeReq <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            wakeReq <= next_wakeReq;
        end
    end

    assign wk.wakeReq = wakeReq;
endmodule

// [rtl/epis_top.sv]
// External pin interrupt sense block with APB register access.
`timescale 1ns/1ns
// ==========================================================
module epis_top (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [epis_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic extIrqPinA,
    input wire logic extIrqPinB,
    input wire logic extIrqPinC,
    input wire logic sleepCmd,
    input wire logic [2:0] isrAck,
    output logic [2:0] extReq,
    output logic asleep,
    output logic ioClkRun,
    output logic wakeUp,
    output logic irq
);
    import epis_pkg::*;

    // ==========================================================
    // Decoding helpers.
    function automatic logic edgeHit(input logic [1:0] sense, input logic cur,
                                     input logic prev);
        logic hit;
        case (sense)
            SENSE_ANY: hit = cur ^ prev;
            SENSE_FALL: hit = prev & ~cur;
            SENSE_RISE: hit = cur & ~prev;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    function automatic logic isLevel(input logic [1:0] sense);
        return sense == SENSE_LOW;
    endfunction

    function automatic logic isAddr(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // ==========================================================
    // Declarations.
    logic [2:0] pinSync;
    logic [2:0] pinPrev;
    logic [2:0] next_pinPrev;
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic senseC;
    logic next_senseC;
    logic [2:0] pinEn;
    logic [2:0] next_pinEn;
    logic [2:0] flags;
    logic [2:0] next_flags;
    logic gie;
    logic next_gie;
    logic [STS_W-1:0] sts;
    logic [STS_W-1:0] next_sts;
    logic [STS_W-1:0] imsk;
    logic [STS_W-1:0] next_imsk;
    logic [31:0] rdData;
    logic [31:0] next_rdData;
    logic [2:0] next_extReq;
    logic [WDT_W-1:0] wdtCnt;
    logic [WDT_W-1:0] next_wdtCnt;
    logic wdtTick;
    epis_sleep_t slp;
    epis_sleep_t next_slp;
    logic next_wakeUp;
    logic [1:0] senseA;
    logic [1:0] senseB;
    logic [2:0] sleepSel;
    logic [2:0] hit;
    logic [2:0] levelMode;
    logic [2:0] levelReq;
    logic wrAcc;
    logic rdSetup;
    logic rdAcc;
    logic mapped;
    logic anyReq;
    epis_wake_if wkIf ();

    // ==========================================================
    // Pin synchroniser and level wake sampler.
    epis_sync uSync (
        .core_clk(core_clk),
        .rst(rst),
        .d({extIrqPinC, extIrqPinB, extIrqPinA}),
        .q(pinSync)
    );

    epis_wake uWake (
        .core_clk(core_clk),
        .rst(rst),
        .wk(wkIf.wake)
    );

    // ==========================================================
    // Field decode.
    assign senseA = ctrl[B_SENSE_A +: 2];
    assign senseB = ctrl[B_SENSE_B +: 2];
    assign sleepSel = {ctrl[B_SLEEP_SEL2], ctrl[B_SLEEP_SEL1], ctrl[B_SLEEP_SEL0]};
    assign levelMode = {1'b0, isLevel(senseB), isLevel(senseA)};

    // ==========================================================
    // Edge detection.
    always_comb begin
        next_pinPrev = pinPrev;
        if (ioClkRun) begin
            next_pinPrev[1:0] = pinSync[1:0];
        end
        next_pinPrev[2] = pinSync[2];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pinPrev <= 3'h7;
        end else begin
            pinPrev <= next_pinPrev;
        end
    end

    // Pin values are read whatever the pin direction.
    always_comb begin
        hit[0] = ioClkRun & edgeHit(senseA, pinSync[0], pinPrev[0]);
        hit[1] = ioClkRun & edgeHit(senseB, pinSync[1], pinPrev[1]);
        if (senseC) begin
            hit[2] = pinSync[2] & ~pinPrev[2];
        end else begin
            hit[2] = pinPrev[2] & ~pinSync[2];
        end
        levelReq = levelMode & ~pinSync;
    end

    // ==========================================================
    // Watchdog oscillator tick divider.
    always_comb begin
        wdtTick = wdtCnt == WDT_W'(WDT_CYC - 1);
        next_wdtCnt = wdtTick ? '0 : wdtCnt + WDT_W'(1);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wdtCnt <= '0;
        end else begin
            wdtCnt <= next_wdtCnt;
        end
    end

    // ==========================================================
    // Sleep control and wake-up.
    assign wkIf.deepSleep = slp == S_DEEP;
    assign wkIf.wdtTick = wdtTick;
    assign wkIf.lvlLow = |(levelReq & pinEn);
    assign anyReq = |(flags & pinEn);

    always_comb begin
        next_slp = slp;
        next_wakeUp = 1'b0;
        case (slp)
            S_RUN: begin
                if (sleepCmd && ctrl[B_SLEEP_ALLOW]) begin
                    next_slp = (sleepSel == SLEEP_IDLE) ? S_IDLE : S_DEEP;
                end
            end
            S_IDLE: begin
                if (anyReq || |(levelReq & pinEn)) begin
                    next_slp = S_RUN;
                    next_wakeUp = 1'b1;
                end
            end
            S_DEEP: begin
                if (wkIf.wakeReq || (flags[2] && pinEn[2])) begin
                    next_slp = S_RUN;
                    next_wakeUp = 1'b1;
                end
            end
            default: begin
                next_slp = S_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            slp <= S_RUN;
            wakeUp <= 1'b0;
        end else begin
            slp <= next_slp;
            wakeUp <= next_wakeUp;
        end
    end

    assign asleep = slp != S_RUN;
    assign ioClkRun = slp != S_DEEP;

    // ==========================================================
    // APB decode.
    assign wrAcc = psel & penable & pwrite;
    assign rdSetup = psel & ~penable & ~pwrite;
    assign rdAcc = psel & penable & ~pwrite;
    assign mapped = isAddr(paddr, OFF_CTRL) | isAddr(paddr, OFF_CSR)
        | isAddr(paddr, OFF_MASK) | isAddr(paddr, OFF_FLAG)
        | isAddr(paddr, OFF_GIE) | isAddr(paddr, OFF_STS)
        | isAddr(paddr, OFF_IMSK) | isAddr(paddr, OFF_PIN);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = rdData;

    // ==========================================================
    // Control registers.
    always_comb begin
        next_ctrl = ctrl;
        next_senseC = senseC;
        next_pinEn = pinEn;
        next_gie = gie;
        next_imsk = imsk;
        if (wrAcc) begin
            if (isAddr(paddr, OFF_CTRL)) begin
                next_ctrl = pwdata[7:0];
            end
            if (isAddr(paddr, OFF_CSR)) begin
                next_senseC = pwdata[B_SENSE_C];
            end
            if (isAddr(paddr, OFF_MASK)) begin
                next_pinEn = {pwdata[B_PIN_C], pwdata[B_PIN_B], pwdata[B_PIN_A]};
            end
            if (isAddr(paddr, OFF_GIE)) begin
                next_gie = pwdata[B_GIE];
            end
            if (isAddr(paddr, OFF_IMSK)) begin
                next_imsk = pwdata[STS_W-1:0];
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl <= RST_CTRL;
            senseC <= RST_SENSE_C;
            pinEn <= RST_PINS;
            gie <= RST_GIE;
            imsk <= RST_STS;
        end else begin
            ctrl <= next_ctrl;
            senseC <= next_senseC;
            pinEn <= next_pinEn;
            gie <= next_gie;
            imsk <= next_imsk;
        end
    end

    // ==========================================================
    // Interrupt flags, requests and sticky status.
    always_comb begin
        next_flags = flags;
        next_flags = next_flags & ~isrAck;
        if (wrAcc && isAddr(paddr, OFF_FLAG)) begin
            next_flags = next_flags & ~{pwdata[B_PIN_C], pwdata[B_PIN_B], pwdata[B_PIN_A]};
        end
        next_flags = next_flags | hit;
        next_flags = next_flags & ~levelMode;
        next_extReq = {3{gie}} & pinEn & (levelReq | flags);
        next_sts = sts;
        if (rdAcc && isAddr(paddr, OFF_STS)) begin
            next_sts = sts & ~rdData[STS_W-1:0];
        end
        next_sts = next_sts | {wakeUp, hit};
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flags <= RST_PINS;
            extReq <= RST_PINS;
            sts <= RST_STS;
        end else begin
            flags <= next_flags;
            extReq <= next_extReq;
            sts <= next_sts;
        end
    end

    assign irq = |(sts & imsk);

    // ==========================================================
    // Read data, captured in the setup cycle.
    always_comb begin
        next_rdData = rdData;
        if (rdSetup) begin
            next_rdData = 32'h0;
            case (1'b1)
                isAddr(paddr, OFF_CTRL): next_rdData[7:0] = ctrl;
                isAddr(paddr, OFF_CSR): next_rdData[B_SENSE_C] = senseC;
                isAddr(paddr, OFF_MASK): begin
                    next_rdData[B_PIN_B] = pinEn[1];
                    next_rdData[B_PIN_A] = pinEn[0];
                    next_rdData[B_PIN_C] = pinEn[2];
                end
                isAddr(paddr, OFF_FLAG): begin
                    next_rdData[B_PIN_B] = flags[1];
                    next_rdData[B_PIN_A] = flags[0];
                    next_rdData[B_PIN_C] = flags[2];
                end
                isAddr(paddr, OFF_GIE): next_rdData[B_GIE] = gie;
                isAddr(paddr, OFF_STS): next_rdData[STS_W-1:0] = sts;
                isAddr(paddr, OFF_IMSK): next_rdData[STS_W-1:0] = imsk;
                isAddr(paddr, OFF_PIN): next_rdData[2:0] = pinSync;
                default: next_rdData = 32'h0;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdData <= 32'h0;
        end else begin
            rdData <= next_rdData;
        end
    end
endmodule

// [verif/epis_checker_props.sv]
// Concurrent checks on the ports of the external pin interrupt sense block.
`timescale 1ns/1ns
module epis_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [epis_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic extIrqPinA,
    input wire logic extIrqPinB,
    input wire logic extIrqPinC,
    input wire logic sleepCmd,
    input wire logic [2:0] isrAck,
    input wire logic [2:0] extReq,
    input wire logic asleep,
    input wire logic ioClkRun,
    input wire logic wakeUp,
    input wire logic irq
);
    import epis_pkg::*;
    // ==========================================================
    // Shadow registers taken from bus writes, and the pin A change history.
    logic [7:0] ctrlS;
    logic [7:0] maskS;
    logic senseC;
    logic gieS;
    logic pinAOld;
    logic [2:0] quietA;
    logic wrEn;
    logic enA;
    logic enB;
    logic enC;
    assign wrEn = psel && penable && pwrite && pready;
    assign enA = gieS && maskS[B_PIN_A];
    assign enB = gieS && maskS[B_PIN_B];
    assign enC = gieS && maskS[B_PIN_C];
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrlS <= 8'h00;
            maskS <= 8'h00;
            senseC <= 1'h0;
            gieS <= 1'h0;
            pinAOld <= 1'h1;
            quietA <= 3'h0;
        end else begin
            ctrlS <= (wrEn && paddr == OFF_CTRL) ? pwdata[7:0] : ctrlS;
            maskS <= (wrEn && paddr == OFF_MASK) ? pwdata[7:0] : maskS;
            senseC <= (wrEn && paddr == OFF_CSR) ? pwdata[B_SENSE_C] : senseC;
            gieS <= (wrEn && paddr == OFF_GIE) ? pwdata[B_GIE] : gieS;
            pinAOld <= extIrqPinA;
            quietA <= (extIrqPinA != pinAOld) ? 3'h0 : ((quietA == 3'h7) ? quietA : quietA + 3'h1);
        end
    end
    // ==========================================================
    // Assertions.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_GIE_GATE: assert property (extReq[0] |-> $past(enA))
        else $error("Request A without both enables.");
    AST_LEVEL_HOLD: assert property ((enA && ctrlS[1:0] == 2'h0 && !asleep && !extIrqPinA)[*5] |-> extReq[0])
        else $error("Level request A missing while pin low.");
    AST_LEVEL_FLAG: assert property (psel && penable && !pwrite && paddr == OFF_FLAG && ctrlS[1:0] == 2'h0 |-> !prdata[B_PIN_A])
        else $error("Flag A reads set in level mode.");
    AST_FALL_A: assert property ($fell(extIrqPinA) && enA && ctrlS[1:0] == 2'h2 && ioClkRun |-> ##[2:5] extReq[0])
        else $error("Falling edge on pin A not requested.");
    AST_RISE_B: assert property ($rose(extIrqPinB) && enB && ctrlS[3:2] == 2'h3 && ioClkRun |-> ##[2:5] extReq[1])
        else $error("Rising edge on pin B not requested.");
    AST_EDGE_C: assert property ((senseC ? $rose(extIrqPinC) : $fell(extIrqPinC)) && enC |-> ##[1:5] extReq[2])
        else $error("Selected edge on pin C not requested.");
    AST_ACK_CLEAR: assert property (isrAck[0] && quietA == 3'h7 && ctrlS[1:0] != 2'h0 |-> ##3 !extReq[0])
        else $error("Acknowledge did not clear request A.");
    AST_IOCLK_SLEEP: assert property (!ioClkRun |-> asleep)
        else $error("I/O clock stopped while awake.");
    AST_WAKE_PULSE: assert property (wakeUp |-> $past(asleep) ##1 !wakeUp)
        else $error("Wake pulse without sleep or longer than one cycle.");
    COV_LEVEL: cover property (enA && !extIrqPinA && extReq[0]);
    COV_DEEP: cover property ($fell(ioClkRun));
    COV_ACK: cover property (isrAck[0] && extReq[0]);
endmodule
bind epis_top epis_checker u_chk (.core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .extIrqPinA(extIrqPinA), .extIrqPinB(extIrqPinB),
    .extIrqPinC(extIrqPinC), .sleepCmd(sleepCmd), .isrAck(isrAck), .extReq(extReq),
    .asleep(asleep), .ioClkRun(ioClkRun), .wakeUp(wakeUp), .irq(irq));

// [verif/epis_pin_model.sv]
// Model of the external sources driving the three interrupt pins.
`timescale 1ns/1ns
module epis_pin_model (
    input wire logic core_clk,
    input wire logic [2:0] levelWant,
    output logic extIrqPinA,
    output logic extIrqPinB,
    output logic extIrqPinC
);
    // ==========================================================
    // Pin drivers.
    // A source holds its level for as long as it is told to.
    initial begin
        extIrqPinA = 1'h1;
        extIrqPinB = 1'h1;
        extIrqPinC = 1'h1;
    end
    always @(posedge core_clk) begin
        extIrqPinA <= levelWant[0];
        extIrqPinB <= levelWant[1];
        extIrqPinC <= levelWant[2];
    end
endmodule

// [verif/external_pin_interrupt_sense_tb.sv]
// Self-checking bench for the external pin interrupt sense block.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin errCount++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module external_pin_interrupt_sense_tb;
    import epis_pkg::*;
    // ==========================================================
    // Stimulus and checks.
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, sleepCmd = 1'h0;
    logic [31:0] pwdata = 32'h0;
    logic [2:0] isrAck = 3'h0;
    logic [2:0] pinWant = 3'h7;
    logic pinA, pinB, pinC, pready, pslverr, asleep, ioClkRun, wakeUp, irq, rde;
    logic [31:0] prdata, rdv;
    logic [2:0] extReq;
    int errCount = 0;
    int nCompared = 0;
    always #50 core_clk = ~core_clk;
    epis_pin_model u_pins (.core_clk(core_clk), .levelWant(pinWant), .extIrqPinA(pinA),
        .extIrqPinB(pinB), .extIrqPinC(pinC));
    epis_top u_dut (.core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .extIrqPinA(pinA), .extIrqPinB(pinB), .extIrqPinC(pinC),
        .sleepCmd(sleepCmd), .isrAck(isrAck), .extReq(extReq), .asleep(asleep),
        .ioClkRun(ioClkRun), .wakeUp(wakeUp), .irq(irq));
    task automatic conclude;
        if (errCount == 0 && nCompared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge core_clk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'h1;
        @(posedge core_clk);
        penable <= 1'h1;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'h1 && k < 16);
        if (k >= 16) begin
            errCount++;
            conclude();
        end
        rdv = prdata;
        rde = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic pulse(input logic s, input logic [2:0] ack);
        @(posedge core_clk);
        sleepCmd <= s;
        isrAck <= ack;
        @(posedge core_clk);
        sleepCmd <= 1'h0;
        isrAck <= 3'h0;
    endtask
    task automatic wait_wake(output int n);
        n = 0;
        while (wakeUp !== 1'h1 && n < 120) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 120) begin
            errCount++;
            conclude();
        end
    endtask
    function automatic logic edge_hit(input logic [1:0] m, input logic o, input logic n);
        case (m)
            2'h1: edge_hit = o ^ n;
            2'h2: edge_hit = o & ~n;
            2'h3: edge_hit = ~o & n;
            default: edge_hit = 1'h0;
        endcase
    endfunction
    initial begin
        int i, n;
        logic [1:0] ma, mb;
        logic mc;
        logic [2:0] old, nw, ex;
        logic [7:0] v;
        void'($urandom(64252));
        tick(5);
        rst <= 1'h0;
        for (i = 0; i < 7; i++) begin
            apb(8'(i * 4), 1'h0, 32'h0);
            `CHK("reset value", 32'h0, rdv)
        end
        for (i = 0; i < 4; i++) begin
            v = 8'($urandom);
            apb(OFF_CTRL, 1'h1, {24'h0, v});
            apb(OFF_CTRL, 1'h0, 32'h0);
            `CHK("control readback", {24'h0, v}, rdv)
        end
        apb(8'h20, 1'h0, 32'h0);
        `CHK("unmapped error", 1'h1, rde)
        apb(OFF_GIE, 1'h1, 32'h1);
        apb(OFF_MASK, 1'h1, 32'hE0);
        for (i = 0; i < 24; i++) begin
            ma = (i < 4) ? 2'(i) : 2'($urandom);
            mb = (i < 4) ? 2'(3 - i) : 2'($urandom);
            mc = 1'($urandom);
            apb(OFF_CTRL, 1'h1, {28'h0, mb, ma});
            apb(OFF_CSR, 1'h1, {25'h0, mc, 6'h0});
            apb(OFF_FLAG, 1'h1, 32'hE0);
            old = pinWant;
            nw = 3'($urandom);
            pinWant <= nw;
            tick(8);
            ex[0] = (ma == 2'h0) ? ~nw[0] : edge_hit(ma, old[0], nw[0]);
            ex[1] = (mb == 2'h0) ? ~nw[1] : edge_hit(mb, old[1], nw[1]);
            ex[2] = edge_hit({1'h1, mc}, old[2], nw[2]);
            `CHK("request A", ex[0], extReq[0])
            `CHK("request B", ex[1], extReq[1])
            `CHK("request C", ex[2], extReq[2])
            apb(OFF_FLAG, 1'h0, 32'h0);
            `CHK("flags", {24'h0, ex[1] & (mb != 2'h0), ex[0] & (ma != 2'h0), ex[2], 5'h0}, rdv)
            if (i % 2 == 1) begin
                pulse(1'h0, 3'h7);
            end else begin
                apb(OFF_FLAG, 1'h1, 32'h60);
            end
            tick(3);
            `CHK("cleared", {1'h0, (i % 2 == 0) ? ex[1] : ~nw[1] & (mb == 2'h0), ~nw[0] & (ma == 2'h0)}, extReq)
        end
        apb(OFF_CTRL, 1'h1, 32'h0);
        apb(OFF_GIE, 1'h1, 32'h0);
        pinWant <= 3'h6;
        tick(6);
        apb(OFF_FLAG, 1'h1, 32'hE0);
        `CHK("global enable off", 3'h0, extReq)
        apb(OFF_GIE, 1'h1, 32'h1);
        apb(OFF_MASK, 1'h1, 32'h0);
        tick(3);
        `CHK("pin mask off", 3'h0, extReq)
        apb(OFF_MASK, 1'h1, 32'h40);
        tick(3);
        `CHK("level request", 3'h1, extReq)
        apb(OFF_MASK, 1'h0, 32'h0);
        `CHK("mask readback", 32'h40, rdv)
        apb(OFF_MASK, 1'h1, 32'hE0);
        pinWant <= 3'h7;
        apb(OFF_CSR, 1'h1, 32'h0);
        apb(OFF_STS, 1'h0, 32'h0);
        apb(OFF_IMSK, 1'h1, 32'h4);
        pinWant <= 3'h3;
        tick(6);
        `CHK("irq on C edge", 1'h1, irq)
        apb(OFF_STS, 1'h0, 32'h0);
        `CHK("status C", 1'h1, rdv[2])
        tick(2);
        `CHK("irq after read", 1'h0, irq)
        apb(OFF_IMSK, 1'h1, 32'h0);
        apb(OFF_CSR, 1'h1, 32'h40);
        pinWant <= 3'h7;
        tick(6);
        `CHK("masked irq", 1'h0, irq)
        apb(OFF_STS, 1'h0, 32'h0);
        `CHK("masked status C", 1'h1, rdv[2])
        apb(OFF_CTRL, 1'h1, 32'h42);
        apb(OFF_FLAG, 1'h1, 32'hE0);
        pulse(1'h1, 3'h0);
        tick(2);
        `CHK("idle clock", 2'h3, {asleep, ioClkRun})
        pinWant <= 3'h6;
        wait_wake(n);
        `CHK("idle edge wake", 1'h1, n < 20)
        tick(1);
        pinWant <= 3'h7;
        apb(OFF_CTRL, 1'h1, 32'h58);
        apb(OFF_FLAG, 1'h1, 32'hE0);
        pulse(1'h1, 3'h0);
        tick(2);
        `CHK("deep clock", 2'h2, {asleep, ioClkRun})
        pinWant <= 3'h5;
        tick(30);
        `CHK("edge in deep sleep", 1'h1, asleep)
        pinWant <= 3'h4;
        wait_wake(n);
        `CHK("level wake time", 1'h1, n >= 40 && n <= 80)
        tick(4);
        `CHK("level after wake", 1'h1, extReq[0])
        pinWant <= 3'h7;
        apb(OFF_FLAG, 1'h1, 32'hE0);
        pulse(1'h1, 3'h0);
        pinWant <= 3'h6;
        tick(28);
        pinWant <= 3'h7;
        wait_wake(n);
        tick(4);
        `CHK("vanished level", 3'h0, extReq)
        conclude();
    end
endmodule
